// ### rtl/byte_alu.sv
// Byte datapath: add, mask, bit modify and bit-test skip on a 128-byte file.
// Assumes a register-bus master with one-cycle strobes and no wait states.
//
// Operation
// - add immediate into accumulator
// - add file register, target selects destination
// - clear chosen bit, flags untouched
// - set chosen bit, flags untouched
// - AND immediate into accumulator
// - AND file register, target selects destination
// - skip next instruction when bit one
// - skip next instruction when bit zero
`timescale 1ns/1ps
module byte_alu (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [byte_alu_pkg::BUS_AW-1:0] i_addr,
   input wire logic [byte_alu_pkg::BUS_DW-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [byte_alu_pkg::BUS_DW-1:0] o_rdata,
   output logic o_skip_next,
   output logic o_busy
);
   import byte_alu_pkg::*;

   logic rst_meta;
   logic rst_n;
   state_e state;
   opcode_e op;
   logic target;
   logic [2:0] bit_sel;
   logic [FILE_AW-1:0] faddr;
   logic [DATA_W-1:0] imm;
   logic [DATA_W-1:0] accum;
   logic carry;
   logic nibble_overflow_bit;
   logic zero;
   logic skip;
   logic [FILE_AW-1:0] sw_faddr;
   logic [DATA_W-1:0] result;
   logic [DATA_W:0] sum9;
   logic [4:0] sum5;
   logic [DATA_W-1:0] operand;
   logic issue;
   logic wr_accum;
   logic wr_flags;
   logic wr_faddr;
   logic wr_fdata;
   logic [4:0] status;
   file_port_if fp ();

   file_memory u_mem (
      .i_clk(i_clk),
      .port(fp.memory)
   );

   // Reset is released through two flops to avoid removal hazards.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Software writes land only while idle, so a result is never torn.
   // An issue during an operation is dropped, not queued.
   always_comb begin
      issue = 1'b0;
      wr_accum = 1'b0;
      wr_flags = 1'b0;
      wr_faddr = 1'b0;
      wr_fdata = 1'b0;
      if (!i_wr || state != ST_IDLE) begin
         issue = 1'b0;
      end else if (i_addr == OFS_ISSUE) begin
         issue = 1'b1;
      end else if (i_addr == OFS_ACCUM) begin
         wr_accum = 1'b1;
      end else if (i_addr == OFS_FLAGS) begin
         wr_flags = 1'b1;
      end else if (i_addr == OFS_FILE_ADDR) begin
         wr_faddr = 1'b1;
      end else if (i_addr == OFS_FILE_DATA) begin
         wr_fdata = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         op <= OP_NONE;
         target <= 1'b0;
         bit_sel <= 3'h0;
         faddr <= 7'h00;
         imm <= 8'h00;
      end else if (issue) begin
         // A pending skip discards this instruction as a no-operation.
         if (skip) begin
            op <= OP_NONE;
         end else begin
            op <= opcode_e'(i_wdata[ISSUE_OP_LSB +: ISSUE_OP_W]);
         end
         target <= i_wdata[ISSUE_TARGET_BIT];
         bit_sel <= i_wdata[ISSUE_BITSEL_LSB +: ISSUE_BITSEL_W];
         faddr <= i_wdata[ISSUE_FADDR_LSB +: FILE_AW];
         imm <= i_wdata[ISSUE_IMM_LSB +: DATA_W];
      end
   end

   // Every operation reads its file register in ST_FETCH, then commits in ST_WRITE.
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (issue) begin
                  state <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               state <= ST_WRITE;
            end
            ST_WRITE: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Immediate forms use the literal; the others use the file byte.
   // Both sums are formed every cycle; only the write phase commits them.
   always_comb begin
      operand = fp.rdata;
      if (op == OP_ADD_IMMEDIATE || op == OP_MASK_IMMEDIATE) begin
         operand = imm;
      end
      sum9 = {1'b0, accum} + {1'b0, operand};
      sum5 = {1'b0, accum[3:0]} + {1'b0, operand[3:0]};
      result = fp.rdata;
      case (op)
         OP_ADD_IMMEDIATE, OP_ADD_TO_REGISTER: begin
            result = sum9[DATA_W-1:0];
         end
         OP_MASK_IMMEDIATE, OP_MASK_REGISTER: begin
            result = accum & operand;
         end
         OP_CLEAR_SELECTED_BIT: begin
            result[bit_sel] = 1'b0;
         end
         OP_SET_SELECTED_BIT: begin
            result[bit_sel] = 1'b1;
         end
         default: begin
            result = fp.rdata;
         end
      endcase
   end

   // The file port is shared with software access when idle.
   always_comb begin
      fp.addr = (state == ST_IDLE) ? sw_faddr : faddr;
      fp.wdata = result;
      fp.we = 1'b0;
      if (state == ST_IDLE) begin
         fp.wdata = i_wdata[DATA_W-1:0];
         fp.we = wr_fdata;
      end else if (state == ST_WRITE) begin
         case (op)
            OP_ADD_TO_REGISTER, OP_MASK_REGISTER: begin
               fp.we = target;
            end
            OP_CLEAR_SELECTED_BIT, OP_SET_SELECTED_BIT: begin
               fp.we = 1'b1;
            end
            default: begin
               fp.we = 1'b0;
            end
         endcase
      end
   end

   // Software pointer into the file for direct writes.
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         sw_faddr <= 7'h00;
      end else if (wr_faddr) begin
         sw_faddr <= i_wdata[FILE_AW-1:0];
      end
   end

   // Accumulator: written by software when idle, or by results.
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         accum <= ACCUM_RST;
      end else if (state == ST_WRITE) begin
         case (op)
            OP_ADD_IMMEDIATE, OP_MASK_IMMEDIATE: begin
               accum <= result;
            end
            OP_ADD_TO_REGISTER, OP_MASK_REGISTER: begin
               if (!target) begin
                  accum <= result;
               end
            end
            default: begin
               accum <= accum;
            end
         endcase
      end else if (wr_accum) begin
         accum <= i_wdata[DATA_W-1:0];
      end
   end

   // Bit operations leave the flags as they were.
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         {zero, nibble_overflow_bit, carry} <= FLAGS_RST;
      end else if (state == ST_WRITE) begin
         case (op)
            OP_ADD_IMMEDIATE, OP_ADD_TO_REGISTER: begin
               carry <= sum9[DATA_W];
               nibble_overflow_bit <= sum5[4];
               zero <= (result == 8'h00);
            end
            OP_MASK_IMMEDIATE, OP_MASK_REGISTER: begin
               zero <= (result == 8'h00);
            end
            default: begin
               zero <= zero;
            end
         endcase
      end else if (wr_flags) begin
         carry <= i_wdata[FLAG_CARRY];
         nibble_overflow_bit <= i_wdata[FLAG_NIBBLE];
         zero <= i_wdata[FLAG_ZERO];
      end
   end

   // Skip holds until the write phase of the next issue, which it turns into a no-operation.
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         skip <= 1'b0;
      end else if (state == ST_WRITE) begin
         if (op == OP_SKIP_WHEN_ONE) begin
            skip <= fp.rdata[bit_sel];
         end else if (op == OP_SKIP_WHEN_ZERO) begin
            skip <= !fp.rdata[bit_sel];
         end else begin
            skip <= 1'b0;
         end
      end
   end

   // Status word as software reads it at the flags offset.
   always_comb begin
      status = 5'h00;
      status[FLAG_CARRY] = carry;
      status[FLAG_NIBBLE] = nibble_overflow_bit;
      status[FLAG_ZERO] = zero;
      status[FLAG_SKIP] = skip;
      status[FLAG_BUSY] = (state != ST_IDLE);
   end

   // Busy rises with the issue and drops one cycle after the sequencer idles; waiting on it is always safe.
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_skip_next <= 1'b0;
         o_busy <= 1'b0;
      end else begin
         o_skip_next <= skip;
         o_busy <= (state != ST_IDLE) || issue;
      end
   end

   // Read data stand for one cycle only; file data are write-only here.
   // The array is seen through operations, which keeps the port simple.
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_rdata <= BUS_ZERO;
      end else if (i_rd) begin
         if (i_addr == OFS_ACCUM) begin
            o_rdata <= {24'h00_0000, accum};
         end else if (i_addr == OFS_FLAGS) begin
            o_rdata <= {27'h000_0000, status};
         end else if (i_addr == OFS_FILE_ADDR) begin
            o_rdata <= {25'h000_0000, sw_faddr};
         end else if (i_addr == OFS_ISSUE) begin
            o_rdata <= {8'h00, imm, 1'b0, faddr, bit_sel, target, op};
         end else begin
            o_rdata <= BUS_ZERO;
         end
      end else begin
         o_rdata <= BUS_ZERO;
      end
   end
endmodule

// ### common/byte_alu_pkg.sv
// Constants and types for the byte ALU datapath with bit modify and skip.
// Assumes one 20 MHz clock and a register bus with one-cycle read latency.
package byte_alu_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FILE_AW = 7;
   localparam int unsigned FILE_DEPTH = 128;
   localparam int unsigned BUS_AW = 8;
   localparam int unsigned BUS_DW = 32;

   // Register offsets (byte addresses).
   localparam logic [BUS_AW-1:0] OFS_ISSUE = 8'h00;
   localparam logic [BUS_AW-1:0] OFS_ACCUM = 8'h04;
   localparam logic [BUS_AW-1:0] OFS_FLAGS = 8'h08;
   localparam logic [BUS_AW-1:0] OFS_FILE_ADDR = 8'h0C;
   localparam logic [BUS_AW-1:0] OFS_FILE_DATA = 8'h10;

   // Fields of the issue register.
   localparam int unsigned ISSUE_OP_LSB = 0;
   localparam int unsigned ISSUE_OP_W = 4;
   localparam int unsigned ISSUE_TARGET_BIT = 4;
   localparam int unsigned ISSUE_BITSEL_LSB = 5;
   localparam int unsigned ISSUE_BITSEL_W = 3;
   localparam int unsigned ISSUE_FADDR_LSB = 8;
   localparam int unsigned ISSUE_IMM_LSB = 16;

   // Flag register bit positions.
   localparam int unsigned FLAG_CARRY = 0;
   localparam int unsigned FLAG_NIBBLE = 1;
   localparam int unsigned FLAG_ZERO = 2;
   localparam int unsigned FLAG_SKIP = 3;
   localparam int unsigned FLAG_BUSY = 4;

   // Cycles that o_busy stays high for one issued operation.
   localparam int unsigned OP_CYCLES = 3;

   localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
   localparam logic [2:0] FLAGS_RST = 3'h0;
   localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_ADD_IMMEDIATE = 4'h1,
      OP_ADD_TO_REGISTER = 4'h2,
      OP_CLEAR_SELECTED_BIT = 4'h3,
      OP_SET_SELECTED_BIT = 4'h4,
      OP_MASK_IMMEDIATE = 4'h5,
      OP_MASK_REGISTER = 4'h6,
      OP_SKIP_WHEN_ONE = 4'h7,
      OP_SKIP_WHEN_ZERO = 4'h8
   } opcode_e;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_FETCH = 3'b010,
      ST_WRITE = 3'b100
   } state_e;
endpackage

// ### common/file_port_if.sv
// Port bundle between the datapath and its register-file memory.
// Assumes both sides run on the one block clock.
`timescale 1ns/1ps
interface file_port_if;
   import byte_alu_pkg::*;
   logic [FILE_AW-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic we;
   logic [DATA_W-1:0] rdata;
   modport master (output addr, output wdata, output we, input rdata);
   modport memory (input addr, input wdata, input we, output rdata);
endinterface

// ### rtl/file_memory.sv
// Register file of 128 bytes with registered read data.
// Assumes one clock; read data appear the cycle after the address.
`timescale 1ns/1ps
module file_memory (
   input wire logic i_clk,
   file_port_if.memory port
);
   import byte_alu_pkg::*;
   logic [DATA_W-1:0] mem [FILE_DEPTH];

   // No reset on the array keeps it a plain memory.
   always_ff @(posedge i_clk) begin
      if (port.we) begin
         mem[port.addr] <= port.wdata;
      end
      port.rdata <= mem[port.addr];
   end
endmodule

// ### verif/byte_alu_assertions.sv
// Port checker for the byte ALU.
// Assumes it is bound onto byte_alu and sees only its top ports.
`timescale 1ns/1ps
module byte_alu_assertions
   import byte_alu_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [BUS_AW-1:0] i_addr,
   input wire logic [BUS_DW-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [BUS_DW-1:0] o_rdata,
   input wire logic o_skip_next,
   input wire logic o_busy
);
   logic go;
   logic [3:0] opf;
   assign go = i_wr && i_addr == OFS_ISSUE && !o_busy;
   assign opf = i_wdata[3:0];
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   property p_add_busy;
      go && opf == OP_ADD_IMMEDIATE |=> o_busy;
   endproperty
   a_add_busy: assert property (p_add_busy) else $error("no busy");
   property p_busy_end;
      $rose(o_busy) |-> ##[1:3] !o_busy;
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy hang");
   property p_busy_cause;
      $rose(o_busy) |-> $past(go);
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy");
   property p_clr_done;
      go && opf == OP_CLEAR_SELECTED_BIT |=> o_busy ##[1:3] (!o_busy &&
         !o_skip_next);
   endproperty
   a_clr_done: assert property (p_clr_done) else $error("clear");
   property p_set_done;
      go && opf == OP_SET_SELECTED_BIT |-> ##[2:4] !o_skip_next;
   endproperty
   a_set_done: assert property (p_set_done) else $error("set");
   property p_mask_done;
      go && opf == OP_MASK_REGISTER |=> o_busy[*2] ##[0:2] !o_skip_next;
   endproperty
   a_mask_done: assert property (p_mask_done) else $error("mask");
   property p_flag_skip;
      i_rd && i_addr == OFS_FLAGS |=> o_rdata[FLAG_SKIP] == o_skip_next;
   endproperty
   a_flag_skip: assert property (p_flag_skip) else $error("flag");
   property p_skip_src;
      $rose(o_skip_next) |-> $past(o_busy) || $past(o_busy, 2);
   endproperty
   a_skip_src: assert property (p_skip_src) else $error("skip");
endmodule

// ### verif/byte_alu_tb_top.sv
// Self-checking bench for the byte ALU over its register port.
// Assumes the checker file is compiled first.
`timescale 1ns/1ps
module byte_alu_tb_top;
   import byte_alu_pkg::*;
   logic i_clk, i_nrst, i_wr, i_rd, o_skip_next, o_busy;
   logic [7:0] i_addr;
   logic [31:0] i_wdata, o_rdata;
   int bad_count, compares;
   byte_alu dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_skip_next(o_skip_next), .o_busy(o_busy));
   always #25 i_clk = ~i_clk;
   task close_out;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (compares > 0 && bad_count == 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'h1;
      @(posedge i_clk);
      i_wr <= 1'h0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'h1;
      @(posedge i_clk);
      i_rd <= 1'h0;
      @(negedge i_clk);
      chk(o_rdata, e);
   endtask
   // Waits on busy with a bound so a stuck datapath cannot hang the run.
   task op(input logic [3:0] c, input logic t, input logic [2:0] b,
      input logic [6:0] f, input logic [7:0] k);
      int n;
      wr(OFS_ISSUE, {8'h00, k, 1'h0, f, b, t, c});
      n = 0;
      @(negedge i_clk);
      while (o_busy !== 1'h0 && n < 20) begin
         @(negedge i_clk);
         n++;
      end
      chk(n, OP_CYCLES);
   endtask
   task acc(input logic [7:0] v);
      op(OP_MASK_IMMEDIATE, 1'h0, 3'h0, 7'h00, 8'h00);
      op(OP_ADD_IMMEDIATE, 1'h0, 3'h0, 7'h00, v);
   endtask
   // The file has no read path, so it is seen through the accumulator.
   task fil(input logic [6:0] f, input logic [7:0] e);
      acc(8'hFF);
      op(OP_MASK_REGISTER, 1'h0, 3'h0, f, 8'h00);
      rd(OFS_ACCUM, {24'h00_0000, e});
   endtask
   task fw(input logic [6:0] f, input logic [7:0] v);
      wr(OFS_FILE_ADDR, {25'h000_0000, f});
      wr(OFS_FILE_DATA, {24'h00_0000, v});
   endtask
   task t_add;
      logic [7:0] a [0:3];
      logic [7:0] k [0:3];
      logic [8:0] s;
      logic [4:0] h;
      a = '{8'hFF, 8'h0F, 8'h80, 8'h12};
      k = '{8'h01, 8'h01, 8'h80, 8'h34};
      rd(OFS_FLAGS, BUS_ZERO);
      rd(8'h40, BUS_ZERO);
      for (int i = 0; i < 4; i++) begin
         acc(a[i]);
         op(OP_ADD_IMMEDIATE, 1'h0, 3'h0, 7'h00, k[i]);
         s = a[i] + k[i];
         h = a[i][3:0] + k[i][3:0];
         rd(OFS_ACCUM, {24'h00_0000, s[7:0]});
         rd(OFS_FLAGS, {29'h0000_0000, s[7:0] == 8'h00, h[4], s[8]});
      end
      rd(OFS_ISSUE, {8'h00, k[3], 8'h00, 4'h0, OP_ADD_IMMEDIATE});
      fw(7'h7F, 8'h33);
      rd(OFS_FILE_ADDR, 32'h0000_007F);
      rd(OFS_FILE_DATA, BUS_ZERO);
      acc(8'h11);
      op(OP_ADD_TO_REGISTER, 1'h0, 3'h0, 7'h7F, 8'h00);
      rd(OFS_ACCUM, 32'h0000_0044);
      op(OP_ADD_TO_REGISTER, 1'h1, 3'h0, 7'h7F, 8'h00);
      rd(OFS_ACCUM, 32'h0000_0044);
      fil(7'h7F, 8'h77);
      $display("add test done");
   endtask
   task t_mask;
      acc(8'hF0);
      op(OP_MASK_IMMEDIATE, 1'h0, 3'h0, 7'h00, 8'h3C);
      rd(OFS_ACCUM, 32'h0000_0030);
      wr(OFS_FLAGS, 32'h0000_0003);
      op(OP_MASK_IMMEDIATE, 1'h0, 3'h0, 7'h00, 8'h0F);
      rd(OFS_FLAGS, 32'h0000_0007);
      fw(7'h05, 8'h5A);
      acc(8'h0F);
      op(OP_MASK_REGISTER, 1'h1, 3'h0, 7'h05, 8'h00);
      rd(OFS_ACCUM, 32'h0000_000F);
      fil(7'h05, 8'h0A);
      acc(8'h0F);
      wr(OFS_ISSUE, {8'h00, 8'h01, 8'h00, 4'h0, OP_ADD_IMMEDIATE});
      wr(OFS_ACCUM, 32'h0000_0055);
      repeat (3) @(negedge i_clk);
      rd(OFS_ACCUM, 32'h0000_0010);
      $display("mask test done");
   endtask
   task t_bits;
      logic [7:0] v;
      v = 8'h00;
      fw(7'h02, v);
      for (int b = 0; b < 8; b++) begin
         wr(OFS_FLAGS, 32'h0000_0005);
         op(OP_SET_SELECTED_BIT, 1'h0, b[2:0], 7'h02, 8'h00);
         v[b] = 1'h1;
         rd(OFS_FLAGS, 32'h0000_0005);
         fil(7'h02, v);
      end
      wr(OFS_FLAGS, 32'h0000_0005);
      op(OP_CLEAR_SELECTED_BIT, 1'h0, 3'h0, 7'h02, 8'h00);
      op(OP_CLEAR_SELECTED_BIT, 1'h0, 3'h7, 7'h02, 8'h00);
      rd(OFS_FLAGS, 32'h0000_0005);
      fil(7'h02, 8'h7E);
      $display("bit test done");
   endtask
   task t_skip;
      logic [3:0] c [0:3];
      logic [2:0] b [0:3];
      logic s [0:3];
      logic [7:0] w;
      c = '{OP_SKIP_WHEN_ONE, OP_SKIP_WHEN_ONE, OP_SKIP_WHEN_ZERO,
         OP_SKIP_WHEN_ZERO};
      b = '{3'h2, 3'h3, 3'h3, 3'h2};
      s = '{1'h1, 1'h0, 1'h1, 1'h0};
      fw(7'h09, 8'h04);
      acc(8'h20);
      w = 8'h20;
      for (int i = 0; i < 4; i++) begin
         wr(OFS_FLAGS, 32'h0000_0002);
         op(c[i], 1'h0, b[i], 7'h09, 8'h00);
         chk({31'h0000_0000, o_skip_next}, {31'h0000_0000, s[i]});
         rd(OFS_FLAGS, {28'h000_0000, s[i], 3'h2});
         op(OP_ADD_IMMEDIATE, 1'h0, 3'h0, 7'h00, 8'h01);
         w = s[i] ? w : w + 8'h01;
         rd(OFS_ACCUM, {24'h00_0000, w});
         chk({31'h0000_0000, o_skip_next}, BUS_ZERO);
      end
      fil(7'h09, 8'h04);
      $display("skip test done");
   endtask
   initial begin
      i_clk = 1'h0;
      i_nrst = 1'h0;
      i_wr = 1'h0;
      i_rd = 1'h0;
      i_addr = 8'h00;
      i_wdata = BUS_ZERO;
      repeat (8) @(posedge i_clk);
      i_nrst <= 1'h1;
      repeat (3) @(posedge i_clk);
      t_add;
      t_mask;
      t_bits;
      t_skip;
      close_out;
   end
   initial begin
      #1_000_000;
      bad_count++;
      close_out;
   end
endmodule
bind byte_alu byte_alu_assertions chk_u (.i_clk(i_clk), .i_nrst(i_nrst),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .o_rdata(o_rdata), .o_skip_next(o_skip_next), .o_busy(o_busy));
